// ---- shared/fss_pkg.sv ----
// Package for the fastening step sequencer: opcodes, sizes, reset values
package fss_pkg;
    // Program store geometry
    localparam int FSS_STEPS = 10;
    localparam int FSS_STEP_W = 4;
    localparam int FSS_PARAM_W = 8;
    localparam int FSS_OP_W = 3;
    localparam int FSS_PRESET_W = 4;
    // Program selections follow the last ordinary preset
    localparam logic [3:0] FSS_LAST_PRESET = 4'h8;
    localparam logic [3:0] FSS_PROG_A_SEL = 4'h9;
    localparam logic [3:0] FSS_PROG_B_SEL = 4'ha;
    // Reset values
    localparam logic [3:0] FSS_RST_STEP = 4'h0;
    localparam logic [7:0] FSS_RST_COUNT = 8'h00;
    localparam logic [3:0] FSS_RST_PRESET = 4'h1;
    // Step opcodes
    localparam logic [2:0] FSS_OP_NOP = 3'h0;
    localparam logic [2:0] FSS_OP_FASTEN = 3'h1;
    localparam logic [2:0] FSS_OP_LOOSEN = 3'h2;
    localparam logic [2:0] FSS_OP_LOAD = 3'h3;
    localparam logic [2:0] FSS_OP_DECSKIP = 3'h4;
    localparam logic [2:0] FSS_OP_JUMP = 3'h5;
    localparam logic [2:0] FSS_OP_PRESET = 3'h6;
    localparam logic [2:0] FSS_OP_END = 3'h7;
    typedef enum logic [2:0] {FSS_IDLE, FSS_FETCH, FSS_EXEC, FSS_WAIT_FASTEN, FSS_WAIT_LOOSEN,
        FSS_DONE} fss_state_e;
endpackage : fss_pkg

// ---- design/fss_angle_counter.sv ----
// Loosening angle counter in tenth-of-turn units
`timescale 1ns/1ps
`default_nettype none
module fss_angle_counter #(
    parameter int PARAM_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic [PARAM_W-1:0] target,
    input wire logic tenth_tick,
    // Result
    output logic reached
);
    logic [PARAM_W-1:0] count_ff;
    logic active_ff;

    // Count tenth-turn ticks; zero target never stops by angle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            count_ff <= '0;
            active_ff <= 1'b0;
            reached <= 1'b0;
        end else begin
            reached <= 1'b0;
            if (start) begin
                count_ff <= '0;
                active_ff <= (target != '0);
            end else if (active_ff && tenth_tick) begin
                if (count_ff + 1'b1 >= target) begin
                    active_ff <= 1'b0;
                    reached <= 1'b1; // One-cycle pulse
                end
                count_ff <= count_ff + 1'b1;
            end
        end
    end
endmodule // fss_angle_counter
`default_nettype wire

// ---- design/fss_sequencer.sv ----
// Fastening step sequencer: runs a ten-step program A or B
`timescale 1ns/1ps
`default_nettype none
module fss_sequencer
    import fss_pkg::*;
#(
    parameter int STEPS = fss_pkg::FSS_STEPS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Program entry from the configuration tool
    input wire logic prog_we,
    input wire logic prog_sel_b,
    input wire logic [fss_pkg::FSS_STEP_W-1:0] prog_addr,
    input wire logic [fss_pkg::FSS_OP_W-1:0] prog_op,
    input wire logic [fss_pkg::FSS_PARAM_W-1:0] prog_param,
    // Run control
    input wire logic [3:0] preset_sel,
    input wire logic start,
    // Motor control feedback
    input wire logic fasten_done,
    input wire logic tenth_turn_tick,
    // Motor control commands
    output logic fasten_start,
    output logic [fss_pkg::FSS_PRESET_W-1:0] fasten_preset,
    output logic loosen_run,
    // Status
    output logic fastening_ok,
    output logic torque_up,
    output logic busy,
    output logic [fss_pkg::FSS_STEP_W-1:0] step_index
);
    import fss_pkg::*;

    // Step slot storage for both programs
    logic [FSS_OP_W-1:0] op_mem [2][STEPS];
    logic [FSS_PARAM_W-1:0] par_mem [2][STEPS];
    fss_state_e state_ff;
    logic prog_b_ff;
    logic [FSS_PARAM_W-1:0] count_a_ff;
    logic [FSS_OP_W-1:0] op_ff;
    logic [FSS_PARAM_W-1:0] par_ff;
    logic angle_start;
    logic angle_reached;

    // Next step number; an index past the last slot ends the program at fetch
    function automatic logic [FSS_STEP_W-1:0] step_add(input logic [FSS_STEP_W-1:0] s, input int n);
        return FSS_STEP_W'(int'(s) + n);
    endfunction

    always_ff @(posedge mclk) begin
        if (prog_we && int'(prog_addr) < STEPS) begin
            op_mem[prog_sel_b][prog_addr] <= prog_op;
            par_mem[prog_sel_b][prog_addr] <= prog_param;
        end
    end

    // Program choice latch
    // Only taken when idle or done, so a start during a motor wait cannot swap programs mid-run
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prog_b_ff <= 1'b0;
        end else if (start && (state_ff == FSS_IDLE || state_ff == FSS_DONE)) begin
            prog_b_ff <= (preset_sel == FSS_PROG_B_SEL);
        end
    end

    // Main sequencing machine; a start selecting program A or B while not busy begins at step one
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff <= FSS_IDLE;
            step_index <= FSS_RST_STEP;
            op_ff <= FSS_OP_NOP;
            par_ff <= '0;
        end else begin
            unique case (state_ff)
                FSS_IDLE, FSS_DONE: begin
                    if (start && (preset_sel == FSS_PROG_A_SEL || preset_sel == FSS_PROG_B_SEL)) begin
                        step_index <= FSS_RST_STEP;
                        state_ff <= FSS_FETCH;
                    end
                end
                FSS_FETCH: begin
                    // Falling off slot ten counts as the end of the program
                    if (int'(step_index) >= STEPS) begin
                        state_ff <= FSS_DONE;
                    end else begin
                        op_ff <= op_mem[prog_b_ff][step_index];
                        par_ff <= par_mem[prog_b_ff][step_index];
                        state_ff <= FSS_EXEC;
                    end
                end
                FSS_EXEC: begin
                    unique case (op_ff)
                        FSS_OP_FASTEN: state_ff <= FSS_WAIT_FASTEN;
                        FSS_OP_LOOSEN: state_ff <= FSS_WAIT_LOOSEN;
                        FSS_OP_END: state_ff <= FSS_DONE;
                        FSS_OP_JUMP: begin
                            step_index <= (par_ff == '0) ? FSS_RST_STEP : FSS_STEP_W'(par_ff - 1'b1);
                            state_ff <= FSS_FETCH;
                        end
                        FSS_OP_DECSKIP: begin
                            step_index <= (count_a_ff <= 8'h01) ? step_add(step_index, 2) : step_add(step_index, 1);
                            state_ff <= FSS_FETCH;
                        end
                        default: begin
                            step_index <= step_add(step_index, 1);
                            state_ff <= FSS_FETCH;
                        end
                    endcase
                end
                FSS_WAIT_FASTEN: begin
                    if (fasten_done) begin
                        step_index <= step_add(step_index, 1);
                        state_ff <= FSS_FETCH;
                    end
                end
                FSS_WAIT_LOOSEN: begin
                    // Without an angle target the loosen ends on the motor's own done
                    if (angle_reached || (par_ff == '0 && fasten_done)) begin
                        step_index <= step_add(step_index, 1);
                        state_ff <= FSS_FETCH;
                    end
                end
            endcase
        end
    end

    // Load counter A; counts body passes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            count_a_ff <= FSS_RST_COUNT;
        end else if (state_ff == FSS_EXEC && op_ff == FSS_OP_LOAD) begin
            count_a_ff <= par_ff;
        end else if (state_ff == FSS_EXEC && op_ff == FSS_OP_DECSKIP && count_a_ff != '0) begin
            count_a_ff <= count_a_ff - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fasten_start <= 1'b0;
            fasten_preset <= FSS_RST_PRESET;
        end else begin
            fasten_start <= state_ff == FSS_EXEC && op_ff == FSS_OP_FASTEN;
            if (state_ff == FSS_EXEC && (op_ff == FSS_OP_FASTEN || op_ff == FSS_OP_PRESET)
                && par_ff != '0 && par_ff <= 8'(FSS_LAST_PRESET)) begin
                fasten_preset <= FSS_PRESET_W'(par_ff);
            end
        end
    end

    assign angle_start = state_ff == FSS_EXEC && op_ff == FSS_OP_LOOSEN;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            loosen_run <= 1'b0;
        end else if (angle_start) begin
            loosen_run <= 1'b1;
        end else if (state_ff != FSS_WAIT_LOOSEN || angle_reached || (par_ff == '0 && fasten_done)) begin
            loosen_run <= 1'b0;
        end
    end

    fss_angle_counter #(
        .PARAM_W(FSS_PARAM_W)
    ) u_angle (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(angle_start),
        .target(par_ff),
        .tenth_tick(tenth_turn_tick),
        .reached(angle_reached)
    );

    // Status outputs: OK held from completion until next start
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fastening_ok <= 1'b0;
            torque_up <= 1'b0;
            busy <= 1'b0;
        end else begin
            torque_up <= state_ff == FSS_WAIT_FASTEN && fasten_done;
            if (state_ff == FSS_EXEC && op_ff == FSS_OP_END) begin
                fastening_ok <= 1'b1;
            end else if (state_ff == FSS_FETCH && step_index == FSS_RST_STEP) begin
                fastening_ok <= 1'b0;
            end
            busy <= state_ff != FSS_IDLE && state_ff != FSS_DONE;
        end
    end
endmodule // fss_sequencer
`default_nettype wire

// ---- testbench/fss_sequencer_chk.sv ----
// Port checker for the fastening step sequencer
`timescale 1ns/1ps
`default_nettype none
module fss_sequencer_chk
    import fss_pkg::*;
(
    // Clock, reset and inputs
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [3:0] preset_sel,
    input wire logic fasten_done,
    // Outputs watched
    input wire logic fasten_start,
    input wire logic [fss_pkg::FSS_PRESET_W-1:0] fasten_preset,
    input wire logic fastening_ok,
    input wire logic torque_up,
    input wire logic busy,
    input wire logic [fss_pkg::FSS_STEP_W-1:0] step_index
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Start that the idle sequencer must accept
    sequence s_take;
        start && !busy && (preset_sel == FSS_PROG_A_SEL || preset_sel == FSS_PROG_B_SEL);
    endsequence
    property p_run; s_take |-> ##[1:3] busy; endproperty
    a_run: assert property (p_run) else $error("accepted start gave no run");
    property p_rst; disable iff (1'b0) !rst_n |=> fasten_preset == FSS_RST_PRESET && !busy && !fastening_ok; endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_tq_cause; torque_up |-> $past(fasten_done); endproperty
    a_tq_cause: assert property (p_tq_cause) else $error("torque up without fastening end");
    property p_tq_pulse; torque_up |=> !torque_up; endproperty
    a_tq_pulse: assert property (p_tq_pulse) else $error("torque up too long");
    property p_fs_pulse; fasten_start |=> !fasten_start; endproperty
    a_fs_pulse: assert property (p_fs_pulse) else $error("fasten start too long");
    property p_ok_mid; torque_up |-> !fastening_ok; endproperty
    a_ok_mid: assert property (p_ok_mid) else $error("ok during a run");
    property p_ok_hold; $fell(fastening_ok) |-> $past(start) || $past(start, 2); endproperty
    a_ok_hold: assert property (p_ok_hold) else $error("ok dropped without start");
    property p_step; busy |-> step_index <= 4'h9; endproperty
    a_step: assert property (p_step) else $error("slot index out of range");
endmodule // fss_sequencer_chk
bind fss_sequencer fss_sequencer_chk u_chk (.mclk(mclk), .rst_n(rst_n), .start(start), .preset_sel(preset_sel),
    .fasten_done(fasten_done), .fasten_start(fasten_start), .fasten_preset(fasten_preset),
    .fastening_ok(fastening_ok), .torque_up(torque_up), .busy(busy), .step_index(step_index));
`default_nettype wire

// ---- testbench/fss_motor_model.sv ----
// Motor control model: answers fastenings, ticks while reversing
`timescale 1ns/1ps
`default_nettype none
module fss_motor_model #(
    parameter int DLY = 4
) (
    // Clock
    input wire logic mclk,
    // Commands
    input wire logic fasten_start,
    input wire logic loosen_run,
    // Feedback
    output logic fasten_done,
    output logic tenth_turn_tick
);
    int cnt = 0;
    int tk = 0;
    initial begin
        fasten_done = 1'b0;
        tenth_turn_tick = 1'b0;
    end
    // Done only after a request, so no stray ends reach the sequencer
    always @(posedge mclk) begin
        fasten_done <= (cnt == 1);
        if (fasten_start) cnt <= DLY;
        else if (cnt != 0) cnt <= cnt - 1;
        tk <= loosen_run ? (tk + 1) % 3 : 0;
        tenth_turn_tick <= loosen_run && tk == 2;
    end
endmodule // fss_motor_model
`default_nettype wire

// ---- testbench/fastening_step_sequencer_tb.sv ----
// Testbench for the fastening step sequencer
`timescale 1ns/1ps
`default_nettype none
module fastening_step_sequencer_tb;
    import fss_pkg::*;
    logic mclk, rst_n, prog_we, prog_sel_b, start, fasten_done, tenth_turn_tick, lr_q;
    logic [3:0] prog_addr, preset_sel, fasten_preset, step_index, pre_seen;
    logic [2:0] prog_op;
    logic [7:0] prog_param;
    logic fasten_start, loosen_run, fastening_ok, torque_up, busy;
    int miscompares = 0;
    int checks_done = 0;
    int n_fs, n_tq, n_ls;
    fss_sequencer u_dut (.mclk(mclk), .rst_n(rst_n), .prog_we(prog_we), .prog_sel_b(prog_sel_b),
        .prog_addr(prog_addr), .prog_op(prog_op), .prog_param(prog_param), .preset_sel(preset_sel),
        .start(start), .fasten_done(fasten_done), .tenth_turn_tick(tenth_turn_tick),
        .fasten_start(fasten_start), .fasten_preset(fasten_preset), .loosen_run(loosen_run),
        .fastening_ok(fastening_ok), .torque_up(torque_up), .busy(busy), .step_index(step_index));
    fss_motor_model u_motor (.mclk(mclk), .fasten_start(fasten_start), .loosen_run(loosen_run),
        .fasten_done(fasten_done), .tenth_turn_tick(tenth_turn_tick));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Event counters for the run under test
    always @(posedge mclk) begin
        if (fasten_start === 1'b1) n_fs++;
        if (fasten_start === 1'b1) pre_seen = fasten_preset;
        if (torque_up === 1'b1) n_tq++;
        if (loosen_run === 1'b1 && lr_q !== 1'b1) n_ls++;
        lr_q <= loosen_run;
    end
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude();
        if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic b, input logic [3:0] a, input logic [2:0] op, input logic [7:0] p);
        @(posedge mclk);
        prog_we <= 1'b1;
        prog_sel_b <= b;
        prog_addr <= a;
        prog_op <= op;
        prog_param <= p;
    endtask
    // Start a program, optionally retry start mid-run, wait until it ends
    task automatic run(input logic [3:0] sel, input logic twice);
        int w;
        @(negedge mclk);
        n_fs = 0;
        n_tq = 0;
        n_ls = 0;
        w = 0;
        @(posedge mclk);
        start <= 1'b1;
        preset_sel <= sel;
        @(posedge mclk);
        start <= 1'b0;
        while (busy !== 1'b1 && w < 20) begin
            @(posedge mclk);
            w++;
        end
        // A start for program B during a fastening wait must change nothing
        if (twice) begin
            while (fasten_start !== 1'b1 && w < 50) begin
                @(posedge mclk);
                w++;
            end
            start <= 1'b1;
            preset_sel <= FSS_PROG_B_SEL;
            @(posedge mclk);
            start <= 1'b0;
            preset_sel <= sel;
        end
        while (busy === 1'b1 && w < 5000) begin
            @(posedge mclk);
            w++;
        end
        @(negedge mclk);
        // A run that never ends counts as a mismatch here
        chk("run_end", busy, 0);
    endtask
    // Worked loop: load ten, fasten, loosen, fasten, decrement, jump back
    task automatic t_loop();
        wr(0, 0, FSS_OP_LOAD, 8'h0a);
        wr(0, 1, FSS_OP_FASTEN, 8'h01);
        wr(0, 2, FSS_OP_LOOSEN, 8'h05);
        wr(0, 3, FSS_OP_FASTEN, 8'h03);
        wr(0, 4, FSS_OP_DECSKIP, 8'h00);
        wr(0, 5, FSS_OP_JUMP, 8'h02);
        wr(0, 6, FSS_OP_END, 8'h00);
        @(posedge mclk);
        prog_we <= 1'b0;
        run(FSS_PROG_A_SEL, 1'b1);
        chk("fastenings", n_fs, 20);
        chk("torque_ups", n_tq, 20);
        chk("loosenings", n_ls, 10);
        chk("preset", fasten_preset, 3);
        chk("ok", fastening_ok, 1);
        chk("busy", busy, 0);
    endtask
    // Count of one skips, refused preset, forward jump, program B
    task automatic t_branch();
        wr(1, 0, FSS_OP_LOAD, 8'h01);
        wr(1, 1, FSS_OP_PRESET, 8'h04);
        wr(1, 2, FSS_OP_DECSKIP, 8'h00);
        wr(1, 3, FSS_OP_FASTEN, 8'h01);
        wr(1, 4, FSS_OP_FASTEN, 8'h00);
        wr(1, 5, FSS_OP_JUMP, 8'h08);
        wr(1, 6, FSS_OP_FASTEN, 8'h02);
        wr(1, 7, FSS_OP_END, 8'h00);
        wr(1, 8, FSS_OP_NOP, 8'h00);
        @(posedge mclk);
        prog_we <= 1'b0;
        run(FSS_PROG_B_SEL, 1'b0);
        chk("b_fastenings", n_fs, 1);
        chk("b_preset", pre_seen, 4);
        chk("b_torque_ups", n_tq, 1);
        chk("b_ok", fastening_ok, 1);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        conclude();
    end
    initial begin
        {rst_n, prog_we, prog_sel_b, start, lr_q} = 5'h00;
        prog_addr = 4'h0;
        prog_op = 3'h0;
        prog_param = 8'h00;
        preset_sel = 4'h0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        chk("reset_preset", fasten_preset, FSS_RST_PRESET);
        // Program B is loaded first so the refused mid-run start in the loop has a real program to swap in
        t_branch();
        t_loop();
        conclude();
    end
endmodule // fastening_step_sequencer_tb
`default_nettype wire
